// File: mso_cfg.svh
`ifndef MSO_CFG_SVH
`define MSO_CFG_SVH
// Register byte offsets
`define MSO_ADDR_VA_MODE 8'h00
`define MSO_ADDR_VA_RANGE 8'h04
`define MSO_ADDR_ZV_RANGE 8'h08
`define MSO_ADDR_TRQ_LIMIT 8'h0c
`define MSO_ADDR_SPD_TYPE 8'h10
`define MSO_ADDR_SPD_RATIO 8'h14
`define MSO_ADDR_SPD_VALUE 8'h18
`define MSO_ADDR_STATUS 8'h1c
`define MSO_ADDR_ACT_NUM 8'h20
`define MSO_ADDR_DEND 8'h24
`define MSO_ADDR_DEND_SEL 8'h40
// Status word field positions
`define MSO_STAT_FLAGS_MSB 6
`define MSO_STAT_TOGGLE_BIT 7
// Reset values
`define MSO_RST_VA_RANGE 16'h000f
`define MSO_RST_ZV_RANGE 16'h000f
`define MSO_RST_TRQ_LIMIT 16'h01f4
`define MSO_RST_SPD_RATIO 7'h32
`define MSO_RST_SPD_VALUE 22'h0003e8
// Legal setting limits
`define MSO_MAX_TRQ_LIMIT 16'h2710
`define MSO_MAX_SPD_RATIO 7'h64
`define MSO_MAX_SPD_VALUE 22'h3d0900
`define MSO_PERCENT 39'h0000000064
`endif

// File: mso_pkg.sv
package mso_pkg;
  // Velocity attainment judgement modes
  typedef enum logic [1:0] {
    MSO_VA_ACTUAL = 2'b00,
    MSO_VA_DEMAND = 2'b01,
    MSO_VA_BOTH = 2'b10
  } mso_va_mode_e;
  // Speed limit setting method
  typedef enum logic {
    MSO_SPD_RATIO = 1'b0,
    MSO_SPD_VALUE = 1'b1
  } mso_spd_type_e;
  // Motion status flags, as seen by the host
  typedef struct packed {
    logic homing_done;
    logic overload_warning;
    logic speed_limited;
    logic input_torque_limited;
    logic slip;
    logic zero_velocity;
    logic velocity_attained;
  } mso_flags_s;
  // Software settings
  typedef struct packed {
    mso_va_mode_e va_mode;
    logic [15:0] va_range;
    logic [15:0] zv_range;
    logic [15:0] trq_limit;
    mso_spd_type_e spd_type;
    logic [6:0] spd_ratio;
    logic [21:0] spd_value;
  } mso_cfg_s;
  typedef logic [7:0] mso_data_num_t;
endpackage : mso_pkg

// File: mso_status.sv
// The register offsets and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`include "mso_cfg.svh"
module mso_status import mso_pkg::*; (
  input wire logic clock,
  input wire logic srst,
  input wire logic [7:0] addr, // Register byte address
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata, // Valid only the cycle after rd_en
  input wire logic signed [31:0] actual_velocity,
  input wire logic signed [31:0] demand_velocity,
  input wire logic signed [31:0] target_velocity,
  input wire logic [31:0] profile_velocity, // Operating velocity of the profile
  input wire logic [31:0] cmd_velocity, // Operating velocity before limiting
  input wire logic speed_limit_setting, // Speed limit requested
  input wire logic slip_detect,
  input wire logic [15:0] output_torque, // 0.1 % of rated
  input wire logic [15:0] overload_threshold, // 0.1 % of rated
  input wire logic torque_limit_request,
  input wire logic homing_start,
  input wire logic homing_complete,
  input wire logic preset_done,
  input wire logic data_op, // Running operation uses stored data
  input wire logic op_start,
  input wire logic [7:0] op_data_number,
  input wire logic data_done, // Current data number completed
  output mso_flags_s flags,
  output logic [31:0] limited_velocity,
  output logic data_change_toggle,
  output mso_data_num_t active_data_number,
  output logic [15:0] data_completion_flags
);

  // Distance between two signed velocities
  function automatic logic [32:0] vel_dist(input logic signed [31:0] a,
                                           input logic signed [31:0] b);
    logic signed [32:0] d;
    d = 33'(a) - 33'(b);
    vel_dist = d[32] ? 33'(-d) : d;
  endfunction : vel_dist

  // Selector slot decode, shared by write and read paths
  function automatic logic is_sel(input logic [7:0] a);
    is_sel = (a[7:6] == 2'(`MSO_ADDR_DEND_SEL >> 6)) && (a[1:0] == 2'h0);
  endfunction : is_sel

  mso_cfg_s cfg; // Settings
  mso_cfg_s next_cfg;
  mso_data_num_t sel [16]; // Completion number selectors
  mso_data_num_t next_sel [16];

  // Settings: out-of-range va_mode, trq_limit, spd_ratio and spd_value writes are dropped; range and type writes keep the low bits
  always_comb begin
    next_cfg = cfg;
    if (wr_en) begin
      unique case (addr)
        `MSO_ADDR_VA_MODE: begin
          if (wdata[31:2] == 30'h0 && wdata[1:0] != 2'h3) begin
            next_cfg.va_mode = mso_va_mode_e'(wdata[1:0]);
          end
        end
        `MSO_ADDR_VA_RANGE: begin
          next_cfg.va_range = wdata[15:0];
        end
        `MSO_ADDR_ZV_RANGE: begin
          next_cfg.zv_range = wdata[15:0];
        end
        `MSO_ADDR_TRQ_LIMIT: begin
          if (wdata <= 32'(`MSO_MAX_TRQ_LIMIT)) begin
            next_cfg.trq_limit = wdata[15:0];
          end
        end
        `MSO_ADDR_SPD_TYPE: begin
          next_cfg.spd_type = mso_spd_type_e'(wdata[0]);
        end
        `MSO_ADDR_SPD_RATIO: begin
          if (wdata != 32'h0 && wdata <= 32'(`MSO_MAX_SPD_RATIO)) begin
            next_cfg.spd_ratio = wdata[6:0];
          end
        end
        `MSO_ADDR_SPD_VALUE: begin
          if (wdata != 32'h0 && wdata <= 32'(`MSO_MAX_SPD_VALUE)) begin
            next_cfg.spd_value = wdata[21:0];
          end
        end
        default: begin
          // Read-only, unmapped or selector slots: ignored here
        end
      endcase
    end
  end

  // Selector next values, one slot per completion flag
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      next_sel[i] = sel[i];
      if (wr_en && is_sel(addr) && addr[5:2] == 4'(i)) begin
        next_sel[i] = wdata[7:0];
      end
    end
  end

  // Settings registers
  always_ff @(posedge clock) begin
    if (srst) begin
      cfg.va_mode <= MSO_VA_ACTUAL;
      cfg.va_range <= `MSO_RST_VA_RANGE;
      cfg.zv_range <= `MSO_RST_ZV_RANGE;
      cfg.trq_limit <= `MSO_RST_TRQ_LIMIT;
      cfg.spd_type <= MSO_SPD_RATIO;
      cfg.spd_ratio <= `MSO_RST_SPD_RATIO;
      cfg.spd_value <= `MSO_RST_SPD_VALUE;
      for (int i = 0; i < 16; i++) begin
        sel[i] <= 8'(i);
      end
    end else begin
      cfg <= next_cfg;
      sel <= next_sel;
    end
  end

  // Motion comparisons
  logic [32:0] dist_demand; // Actual to demand
  logic [32:0] dist_target; // Actual to target
  logic [32:0] act_mag; // Magnitude of actual velocity
  logic [38:0] ratio_prod; // Profile velocity times percent
  logic [31:0] spd_limit; // Active speed limit
  assign dist_demand = vel_dist(actual_velocity, demand_velocity);
  assign dist_target = vel_dist(actual_velocity, target_velocity);
  assign act_mag = vel_dist(actual_velocity, 32'sh0);
  assign ratio_prod = 39'(profile_velocity) * 39'(cfg.spd_ratio);
  // Constant divide is costly in area but only ever sees legal ratios
  assign spd_limit = (cfg.spd_type == MSO_SPD_VALUE) ? 32'(cfg.spd_value) :
                     32'(ratio_prod / `MSO_PERCENT);

  mso_flags_s next_flags;
  logic [31:0] next_limited;

  // Flags other than homing_done are recomputed every cycle from current inputs
  always_comb begin
    next_flags = flags;
    next_flags.velocity_attained = 1'b0;
    unique case (cfg.va_mode)
      MSO_VA_ACTUAL: begin
        next_flags.velocity_attained = dist_demand <= 33'(cfg.va_range);
      end
      MSO_VA_DEMAND: begin
        next_flags.velocity_attained = demand_velocity == target_velocity;
      end
      MSO_VA_BOTH: begin
        next_flags.velocity_attained = dist_target <= 33'(cfg.va_range);
      end
    endcase
    next_flags.zero_velocity = act_mag <= 33'(cfg.zv_range);
    next_flags.slip = slip_detect;
    next_flags.input_torque_limited = torque_limit_request &&
                                      output_torque >= cfg.trq_limit;
    next_flags.speed_limited = speed_limit_setting && cmd_velocity >= spd_limit;
    next_flags.overload_warning = output_torque >= overload_threshold;
    // Set beats clear so a completion racing a new homing is not lost
    if (homing_complete || preset_done) begin
      next_flags.homing_done = 1'b1;
    end else if (homing_start) begin
      next_flags.homing_done = 1'b0;
    end
    next_limited = next_flags.speed_limited ? spd_limit : cmd_velocity;
  end

  // Registered flags so the host never sees comparator glitches
  always_ff @(posedge clock) begin
    if (srst) begin
      flags <= '0;
      limited_velocity <= 32'h0;
    end else begin
      flags <= next_flags;
      limited_velocity <= next_limited;
    end
  end

  logic next_toggle;
  mso_data_num_t next_active;
  logic [15:0] next_dend;
  logic num_change; // Data number moved on mid operation
  assign num_change = op_data_number != active_data_number;

  // Data indicators: only data operations touch them
  always_comb begin
    next_toggle = data_change_toggle;
    next_active = active_data_number;
    if (data_op) begin
      next_toggle = data_change_toggle ^ (op_start || num_change);
      next_active = op_data_number;
    end
  end

  // One completion flag per slot; set wins over the start clear
  for (genvar g = 0; g < 16; g++) begin : g_dend
    always_comb begin
      next_dend[g] = data_completion_flags[g];
      if (data_op && data_done && op_data_number == sel[g]) begin
        next_dend[g] = 1'b1;
      end else if (data_op && op_start) begin
        next_dend[g] = 1'b0;
      end
    end
  end

  // Data indicator registers
  always_ff @(posedge clock) begin
    if (srst) begin
      data_change_toggle <= 1'b0;
      active_data_number <= 8'h00;
      data_completion_flags <= 16'h0000;
    end else begin
      data_change_toggle <= next_toggle;
      active_data_number <= next_active;
      data_completion_flags <= next_dend;
    end
  end

  logic [31:0] next_rdata;

  // Read mux; data shows only in the cycle after the strobe
  always_comb begin
    next_rdata = 32'h0;
    if (rd_en) begin
      if (is_sel(addr)) begin
        next_rdata = 32'(sel[addr[5:2]]);
      end else begin
        unique case (addr)
          `MSO_ADDR_VA_MODE: next_rdata = 32'(cfg.va_mode);
          `MSO_ADDR_VA_RANGE: next_rdata = 32'(cfg.va_range);
          `MSO_ADDR_ZV_RANGE: next_rdata = 32'(cfg.zv_range);
          `MSO_ADDR_TRQ_LIMIT: next_rdata = 32'(cfg.trq_limit);
          `MSO_ADDR_SPD_TYPE: next_rdata = 32'(cfg.spd_type);
          `MSO_ADDR_SPD_RATIO: next_rdata = 32'(cfg.spd_ratio);
          `MSO_ADDR_SPD_VALUE: next_rdata = 32'(cfg.spd_value);
          `MSO_ADDR_STATUS: begin
            next_rdata[`MSO_STAT_FLAGS_MSB:0] = flags;
            next_rdata[`MSO_STAT_TOGGLE_BIT] = data_change_toggle;
          end
          `MSO_ADDR_ACT_NUM: next_rdata = 32'(active_data_number);
          `MSO_ADDR_DEND: next_rdata = 32'(data_completion_flags);
          default: next_rdata = 32'h0; // Unmapped reads as zero
        endcase
      end
    end
  end

  // Read data register
  always_ff @(posedge clock) begin
    if (srst) begin
      rdata <= 32'h0;
    end else begin
      rdata <= next_rdata;
    end
  end

  // Checks
  property p_va_demand;
    @(posedge clock) disable iff (srst)
      (cfg.va_mode == MSO_VA_DEMAND && demand_velocity == target_velocity)
        |=> flags.velocity_attained;
  endproperty
  a_va_demand: assert property (p_va_demand) else $error("attained flag missed");

  property p_zv;
    @(posedge clock) disable iff (srst)
      (act_mag > 33'(cfg.zv_range)) |=> !flags.zero_velocity;
  endproperty
  a_zv: assert property (p_zv) else $error("zero velocity set out of range");

  property p_trq_off;
    @(posedge clock) disable iff (srst)
      !torque_limit_request |=> !flags.input_torque_limited;
  endproperty
  a_trq_off: assert property (p_trq_off) else $error("torque flag without request");

  property p_trq_on;
    @(posedge clock) disable iff (srst)
      (torque_limit_request && output_torque >= cfg.trq_limit)
        |=> flags.input_torque_limited;
  endproperty
  a_trq_on: assert property (p_trq_on) else $error("torque flag missed");

  property p_clamp;
    @(posedge clock) disable iff (srst)
      (speed_limit_setting && cmd_velocity >= spd_limit)
        |=> flags.speed_limited && limited_velocity == $past(spd_limit);
  endproperty
  a_clamp: assert property (p_clamp) else $error("speed not clamped");

  property p_ovl;
    @(posedge clock) disable iff (srst)
      (output_torque >= overload_threshold) |=> flags.overload_warning;
  endproperty
  a_ovl: assert property (p_ovl) else $error("overload warning missed");

  property p_home;
    @(posedge clock) disable iff (srst)
      (homing_complete || preset_done) |=> flags.homing_done;
  endproperty
  a_home: assert property (p_home) else $error("homing done missed");

  property p_toggle;
    @(posedge clock) disable iff (srst)
      (data_op && op_start) |=> data_change_toggle != $past(data_change_toggle);
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle did not invert");

  property p_hold;
    @(posedge clock) disable iff (srst)
      !data_op |=> $stable(active_data_number) && $stable(data_completion_flags);
  endproperty
  a_hold: assert property (p_hold) else $error("indicators moved outside data op");

  property p_dend_clr;
    @(posedge clock) disable iff (srst)
      (data_op && op_start && !data_done) |=> data_completion_flags == 16'h0;
  endproperty
  a_dend_clr: assert property (p_dend_clr) else $error("completion not cleared");

  // Slip is a plain registered copy, so it must trail its input by one cycle
  property p_slip;
    @(posedge clock) disable iff (srst)
      1'b1 |=> flags.slip == $past(slip_detect);
  endproperty
  a_slip: assert property (p_slip) else $error("slip flag does not follow input");

  property p_active;
    @(posedge clock) disable iff (srst)
      data_op |=> active_data_number == $past(op_data_number);
  endproperty
  a_active: assert property (p_active) else $error("active number not shown");

  property p_dend_set;
    @(posedge clock) disable iff (srst)
      (data_op && data_done && op_data_number == sel[0]) |=> data_completion_flags[0];
  endproperty
  a_dend_set: assert property (p_dend_set) else $error("completion flag not set");

  c_va_both: cover property (@(posedge clock) disable iff (srst)
    cfg.va_mode == MSO_VA_BOTH ##1 flags.velocity_attained);
  c_clamp: cover property (@(posedge clock) disable iff (srst)
    !flags.speed_limited ##1 flags.speed_limited);
  c_dend: cover property (@(posedge clock) disable iff (srst)
    data_op && op_start ##[1:20] data_completion_flags != 16'h0);
  c_home: cover property (@(posedge clock) disable iff (srst)
    !flags.homing_done ##1 flags.homing_done);

endmodule : mso_status

// File: mso_host_model.sv
`timescale 1ns/1ps
// Host side of the status outputs: samples levels once a cycle and
// counts how often the data change toggle has flipped since reset
module mso_host_model (
  input wire logic clock,
  input wire logic srst,
  input wire logic data_change_toggle,
  output logic [7:0] toggle_count
);
  logic seen; // Toggle level at the previous sample
  logic [7:0] next_toggle_count;
  // An inversion is an event, so the host compares against the last sample
  always_comb begin
    next_toggle_count = toggle_count;
    if (data_change_toggle != seen) begin
      next_toggle_count = toggle_count + 8'h01;
    end
  end
  // Sample once per cycle; registered outputs make a single sample safe
  always_ff @(posedge clock) begin
    if (srst) begin
      seen <= 1'b0;
      toggle_count <= 8'h00;
    end else begin
      seen <= data_change_toggle;
      toggle_count <= next_toggle_count;
    end
  end
endmodule : mso_host_model

// File: tb_top.sv
`timescale 1ns/1ps
module tb_top import mso_pkg::*;;
  logic clock, srst, wr_en, rd_en;
  logic [7:0] addr, op_data_number, active_data_number, toggle_count;
  logic [31:0] wdata, rdata, profile_velocity, cmd_velocity, limited_velocity;
  logic signed [31:0] actual_velocity, demand_velocity, target_velocity;
  logic speed_limit_setting, slip_detect, torque_limit_request, data_op, data_change_toggle;
  logic homing_start, homing_complete, preset_done, op_start, data_done;
  logic [15:0] output_torque, overload_threshold, data_completion_flags;
  mso_flags_s flags;
  int mismatches, n_compared, i;
  logic tog; // Expected toggle level
  mso_status u_mso_status (.clock(clock), .srst(srst), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .actual_velocity(actual_velocity),
    .demand_velocity(demand_velocity), .target_velocity(target_velocity),
    .profile_velocity(profile_velocity), .cmd_velocity(cmd_velocity),
    .speed_limit_setting(speed_limit_setting), .slip_detect(slip_detect),
    .output_torque(output_torque), .overload_threshold(overload_threshold),
    .torque_limit_request(torque_limit_request), .homing_start(homing_start),
    .homing_complete(homing_complete), .preset_done(preset_done), .data_op(data_op),
    .op_start(op_start), .op_data_number(op_data_number), .data_done(data_done),
    .flags(flags), .limited_velocity(limited_velocity),
    .data_change_toggle(data_change_toggle), .active_data_number(active_data_number),
    .data_completion_flags(data_completion_flags));
  mso_host_model u_mso_host_model (.clock(clock), .srst(srst),
    .data_change_toggle(data_change_toggle), .toggle_count(toggle_count));
  // 50 MHz clock
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // Verdict and end of run, reached from the sequence and the watchdog
  task automatic close_out();
    if (mismatches == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      mismatches++;
    end
  endtask : chk
  // One flag bit: 0 attained, 1 zero, 2 slip, 3 torque, 4 speed, 5 overload, 6 homing
  task automatic chkf(input int idx, input logic e);
    chk({31'h0, flags[idx]}, {31'h0, e});
  endtask : chkf
  task automatic tick();
    @(posedge clock);
    #1;
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask : rd
  task automatic vel(input int a, input int d, input int t);
    @(posedge clock);
    actual_velocity <= a;
    demand_velocity <= d;
    target_velocity <= t;
    tick();
  endtask : vel
  // One-cycle event pulses: {preset, homing done, homing start, data done, start}
  task automatic ev(input logic [4:0] m, input logic [7:0] num);
    @(posedge clock);
    {preset_done, homing_complete, homing_start, data_done, op_start} <= m;
    op_data_number <= num;
    @(posedge clock);
    {preset_done, homing_complete, homing_start, data_done, op_start} <= 5'h00;
    #1;
  endtask : ev
  // Watchdog: every wait is fixed, so this only guards against a stuck run
  initial begin
    repeat (5000) @(posedge clock);
    mismatches++;
    close_out();
  end
  initial begin
    srst = 1'b1; wr_en = 1'b0; rd_en = 1'b0; addr = 8'h00; wdata = 32'h0;
    actual_velocity = 0; demand_velocity = 0; target_velocity = 0;
    profile_velocity = 32'h0; cmd_velocity = 32'h0; speed_limit_setting = 1'b0;
    slip_detect = 1'b0; output_torque = 16'h0; overload_threshold = 16'hffff;
    torque_limit_request = 1'b0; homing_start = 1'b0; homing_complete = 1'b0;
    preset_done = 1'b0; data_op = 1'b0; op_start = 1'b0; op_data_number = 8'h00;
    data_done = 1'b0; mismatches = 0; n_compared = 0; tog = 1'b0;
    repeat (10) @(posedge clock);
    srst <= 1'b0;
    // Reset values of every setting, then an unmapped place
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0000000f);
    rd(8'h08, 32'h0000000f);
    rd(8'h0c, 32'h000001f4);
    rd(8'h10, 32'h0);
    rd(8'h14, 32'h00000032);
    rd(8'h18, 32'h000003e8);
    for (i = 0; i < 16; i++) rd(8'(64 + 4 * i), 32'(i));
    rd(8'h3c, 32'h0);
    // Out-of-range settings are dropped, the boundary is kept
    wr(8'h00, 32'h3); wr(8'h0c, 32'd10001); wr(8'h14, 32'h0); wr(8'h14, 32'd101);
    wr(8'h18, 32'd4000001);
    rd(8'h00, 32'h0);
    rd(8'h0c, 32'h000001f4);
    rd(8'h14, 32'h00000032);
    rd(8'h18, 32'h000003e8);
    wr(8'h0c, 32'd10000);
    rd(8'h0c, 32'd10000);
    // Zero velocity and the three attainment modes, at the range edges
    vel(-15, 0, 0); chkf(1, 1'b1);
    vel(16, 0, 0); chkf(1, 1'b0);
    vel(115, 100, 0); chkf(0, 1'b1);
    vel(116, 100, 0); chkf(0, 1'b0);
    wr(8'h00, 32'h1);
    vel(0, 50, 50); chkf(0, 1'b1);
    vel(0, 50, 51); chkf(0, 1'b0);
    wr(8'h00, 32'h2);
    vel(85, 0, 100); chkf(0, 1'b1);
    vel(84, 84, 100); chkf(0, 1'b0);
    // Slip, torque limit at its maximum, overload threshold
    @(posedge clock); slip_detect <= 1'b1; tick(); chkf(2, 1'b1);
    @(posedge clock); slip_detect <= 1'b0; tick(); chkf(2, 1'b0);
    @(posedge clock); torque_limit_request <= 1'b1; output_torque <= 16'd10000;
    tick(); chkf(3, 1'b1);
    @(posedge clock); output_torque <= 16'd9999; tick(); chkf(3, 1'b0);
    @(posedge clock); torque_limit_request <= 1'b0; output_torque <= 16'd10000;
    tick(); chkf(3, 1'b0);
    @(posedge clock); overload_threshold <= 16'd10001; tick(); chkf(5, 1'b0);
    @(posedge clock); overload_threshold <= 16'd10000; tick(); chkf(5, 1'b1);
    // Speed limit: half of 1000 by ratio, then 1000 by value
    @(posedge clock); speed_limit_setting <= 1'b1; profile_velocity <= 32'd1000;
    cmd_velocity <= 32'd600; tick(); chkf(4, 1'b1);
    chk(limited_velocity, 32'd500);
    @(posedge clock); cmd_velocity <= 32'd499; tick(); chkf(4, 1'b0);
    chk(limited_velocity, 32'd499);
    wr(8'h10, 32'h1);
    @(posedge clock); cmd_velocity <= 32'd1200; tick(); chkf(4, 1'b1);
    chk(limited_velocity, 32'd1000);
    // Homing done by preset, cleared by a new homing, set on completion
    ev(5'h10, 8'h00); chkf(6, 1'b1);
    ev(5'h04, 8'h00); chkf(6, 1'b0);
    ev(5'h08, 8'h00); chkf(6, 1'b1);
    // Stored data operation: start, completion, number change, restart
    wr(8'h40, 32'h5);
    @(posedge clock); data_op <= 1'b1;
    ev(5'h01, 8'h03); tog = ~tog;
    chk({31'h0, data_change_toggle}, {31'h0, tog});
    chk({24'h0, active_data_number}, 32'h3);
    ev(5'h02, 8'h03); chk({16'h0, data_completion_flags}, 32'h0008);
    ev(5'h00, 8'h05); tog = ~tog;
    chk({31'h0, data_change_toggle}, {31'h0, tog});
    chk({24'h0, active_data_number}, 32'h5);
    ev(5'h02, 8'h05); chk({16'h0, data_completion_flags}, 32'h0029);
    rd(8'h24, 32'h00000029);
    ev(5'h01, 8'h05); tog = ~tog;
    chk({16'h0, data_completion_flags}, 32'h0);
    chk({31'h0, data_change_toggle}, {31'h0, tog});
    // Non-data operation: indicators hold
    @(posedge clock); data_op <= 1'b0;
    ev(5'h01, 8'h09); chk({24'h0, active_data_number}, 32'h5);
    ev(5'h02, 8'h05); chk({16'h0, data_completion_flags}, 32'h0);
    chk({31'h0, data_change_toggle}, {31'h0, tog});
    chk({24'h0, toggle_count}, 32'h3);
    // Status word: homing, overload and speed flags up, toggle high
    rd(8'h1c, 32'h000000f0);
    rd(8'h20, 32'h00000005);
    close_out();
  end
endmodule : tb_top
